// >>> hw/nsa_fifo.sv
// Purpose: command fifo in front of the register engine
// Assumes: depth is a power of two
// Notes:   in-side ready comes straight from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module nsa_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// streams
	nsa_stream_if.snk wr,
	nsa_stream_if.src rd
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          rdy_r;
	wire           push = wr.valid & rdy_r;
	wire           pop  = rd.valid & rd.ready;

	assign wr.ready = rdy_r;
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem[rp_r];
	assign cnt_nxt  = cnt_r + CW'(push) - CW'(pop);

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_r] <= wr.data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end else begin
			wp_r  <= push ? wp_r + PW'(1) : wp_r;
			rp_r  <= pop ? rp_r + PW'(1) : rp_r;
			cnt_r <= cnt_nxt;
			rdy_r <= (cnt_nxt != CW'(DEPTH));
		end
	end
endmodule // nsa_fifo
`default_nettype wire

// >>> hw/nsa_top.sv
// Purpose: indirect access to eeprom and shadow sram behind i2c registers
// Assumes: i2c slave delivers start, write, read and stop as a command stream
// Notes:   eeprom contents are not cleared by reset; sram is
//
// Summary of operation
// R01 - read-only live crc byte, resets zero
// R02 - start address register, seven bits used
// R03 - internal address advances, start register unchanged
// R04 - array byte address uses low five bits
// R05 - first eeprom port read returns start byte
// R06 - further eeprom reads advance to next byte
// R07 - eeprom port access locks register pointer
// R08 - transaction end releases eeprom port lock
// R09 - first sram access uses start address
// R10 - further sram accesses advance internal address
// R11 - sram port access locks register pointer
// R12 - transaction end releases sram port lock
// R13 - key write must immediately precede start
// R14 - host writes key value to unlock
// R15 - start only after preceding correct key transaction
// R16 - busy during cycle, eeprom blocked, 115ms
// R17 - other registers auto-increment register pointer
`timescale 1ns/1ps
`default_nettype none
module nsa_top
	import nsa_pkg::*;
#(
	parameter int PROG_CYCLES = NV_CYCLE_CYCLES,
	parameter int CMD_DEPTH   = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// command stream from i2c slave
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_kind,
	input  wire logic [7:0] cmd_data,
	output logic            cmd_ready,
	// read answer
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	// status
	output logic            nonvolatile_busy_flag
);
	// ----------------------------------------------------------------
	// types and widths
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {NV_IDLE, NV_WAIT, NV_COPY} nsa_nv_state_type;

	localparam int CNT_W = $clog2(PROG_CYCLES + 1);
	localparam int AW    = ARRAY_ADDR_W;

	// ----------------------------------------------------------------
	// command fifo
	// ----------------------------------------------------------------
	nsa_stream_if #(.W(CMD_W)) in_if ();
	nsa_stream_if #(.W(CMD_W)) out_if ();

	assign in_if.valid = cmd_valid;
	assign in_if.data  = {cmd_kind, cmd_data};
	assign cmd_ready   = in_if.ready;

	nsa_fifo #(
		.W     (CMD_W),
		.DEPTH (CMD_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr      (in_if.snk),
		.rd      (out_if.src)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]        ptr_r;
	logic              lock_r;
	logic [AW-1:0]     mem_addr_r;
	logic [ADR_FIELD_W-1:0] start_adr_r;
	logic [7:0]        key_r;
	logic              tr_key_ok_r;
	logic              tr_other_r;
	logic              armed_r;
	logic              rd_valid_r;
	logic [7:0]        rd_data_r;
	logic [7:0]        sram_r [ARRAY_DEPTH];
	logic [7:0]        eep_r  [ARRAY_DEPTH];
	nsa_nv_state_type  nv_r;
	logic [CNT_W-1:0]  wait_cnt_r;
	logic [AW-1:0]     copy_idx_r;
	logic              busy_r;
	logic              prog_r;
	logic              erase_r;
	logic [AW-1:0]     crc_idx_r;
	logic [7:0]        crc_acc_r;
	logic [7:0]        live_crc_r;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire [1:0] kind     = out_if.data[CMD_W-1:8];
	wire [7:0] cbyte    = out_if.data[7:0];
	wire       is_start = (kind == KIND_START);
	wire       is_stop  = (kind == KIND_STOP);
	wire       is_wr    = (kind == KIND_WRITE);
	wire       is_rd    = (kind == KIND_READ);
	wire       is_acc   = is_wr | is_rd;
	wire       hit_eep  = (ptr_r == OFS_EEP);
	wire       hit_ram  = (ptr_r == OFS_RAM);
	wire       hit_port = hit_eep | hit_ram;

	// R16 eeprom access blocked
	assign out_if.ready = ~(busy_r & is_acc & hit_port);

	wire       take     = out_if.valid & out_if.ready;
	wire       t_start  = take & is_start;
	wire       t_stop   = take & is_stop;
	wire       t_acc    = take & is_acc;
	wire       t_wr     = take & is_wr;
	wire       t_rd     = take & is_rd;
	wire       port_acc = t_acc & hit_port;

	// R04 low five address bits
	wire [AW-1:0] start_byte = start_adr_r[AW-1:0];
	// R06 next byte after first
	wire [AW-1:0] addr_use   = lock_r ? mem_addr_r + AW'(1) : start_byte;

	wire       sram_we  = t_wr & hit_ram;
	wire       wr_adr   = t_wr & (ptr_r == OFS_ADR);
	wire       wr_key   = t_wr & (ptr_r == OFS_KEY);
	wire       wr_ctl   = t_wr & (ptr_r == OFS_CTL);
	// R14 key value compare
	wire       key_good = wr_key & (cbyte == UNLOCK_CODE);
	wire       want_go  = cbyte[CTL_PROG_BIT] | cbyte[CTL_ERASE_BIT];
	// R15 preceding transaction armed
	wire       ctl_go   = wr_ctl & want_go & armed_r & ~busy_r;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [7:0] ctl_rd;
	always_comb begin
		ctl_rd                = '0;
		ctl_rd[CTL_PROG_BIT]  = prog_r;
		ctl_rd[CTL_ERASE_BIT] = erase_r;
		ctl_rd[CTL_BUSY_BIT]  = busy_r;
	end

	wire [7:0] adr_rd  = {1'b0, start_adr_r};
	wire [7:0] rd_mux  = (ptr_r == OFS_CTL) ? ctl_rd :
	                     (ptr_r == OFS_CRC) ? live_crc_r :
	                     (ptr_r == OFS_ADR) ? adr_rd :
	                     hit_eep            ? eep_r[addr_use] :
	                     hit_ram            ? sram_r[addr_use] :
	                     (ptr_r == OFS_KEY) ? key_r :
	                     RST_BYTE;

	// ----------------------------------------------------------------
	// register pointer and port lock
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ptr_r <= RST_BYTE;
		end else if (t_start) begin
			ptr_r <= cbyte;
		end else if (t_acc && !hit_port) begin
			// R17 pointer auto-increment
			ptr_r <= ptr_r + 8'h01;
		end
	end

	// R07 R11 pointer stays locked
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lock_r <= 1'b0;
		end else if (t_start || t_stop) begin
			// R08 R12 lock ends
			lock_r <= 1'b0;
		end else if (port_acc) begin
			lock_r <= 1'b1;
		end
	end

	// R03 internal address only
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_addr_r <= '0;
		end else if (port_acc) begin
			mem_addr_r <= addr_use;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			start_adr_r <= '0;
			key_r       <= RST_BYTE;
		end else begin
			// R02 start address store
			if (wr_adr) begin
				start_adr_r <= cbyte[ADR_FIELD_W-1:0];
			end
			if (wr_key) begin
				key_r <= cbyte;
			end
		end
	end

	// R13 key transaction tracking
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tr_key_ok_r <= 1'b0;
			tr_other_r  <= 1'b0;
			armed_r     <= 1'b0;
		end else begin
			if (t_start) begin
				tr_key_ok_r <= 1'b0;
				tr_other_r  <= 1'b0;
			end else if (key_good) begin
				tr_key_ok_r <= 1'b1;
			end else if (t_acc) begin
				tr_other_r <= 1'b1;
			end
			if (t_stop) begin
				armed_r <= tr_key_ok_r & ~tr_other_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	// R05 R09 first access at start
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_valid_r <= 1'b0;
			rd_data_r  <= RST_BYTE;
		end else begin
			rd_valid_r <= t_rd;
			if (t_rd) begin
				rd_data_r <= rd_mux;
			end
		end
	end

	assign rd_valid = rd_valid_r;
	assign rd_data  = rd_data_r;

	// ----------------------------------------------------------------
	// arrays
	// ----------------------------------------------------------------
	wire       copy_we   = (nv_r == NV_COPY);
	wire [7:0] copy_byte = prog_r ? sram_r[copy_idx_r] : ERASED_BYTE;

	for (genvar i = 0; i < ARRAY_DEPTH; i++) begin : g_entry
		localparam logic [AW-1:0] IDX = AW'(i);

		// R10 sram write at address
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				sram_r[i] <= RST_BYTE;
			end else if (sram_we && addr_use == IDX) begin
				sram_r[i] <= cbyte;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (copy_we && copy_idx_r == IDX) begin
				eep_r[i] <= copy_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// erase / program sequencer
	// ----------------------------------------------------------------
	wire wait_done = (wait_cnt_r == CNT_W'(PROG_CYCLES - 1));
	wire copy_done = (copy_idx_r == AW'(ARRAY_DEPTH - 1));

	// R16 busy for full cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			nv_r       <= NV_IDLE;
			wait_cnt_r <= '0;
			copy_idx_r <= '0;
			busy_r     <= 1'b0;
			prog_r     <= 1'b0;
			erase_r    <= 1'b0;
		end else begin
			unique case (nv_r)
				NV_IDLE: begin
					if (ctl_go) begin
						nv_r       <= NV_WAIT;
						wait_cnt_r <= '0;
						busy_r     <= 1'b1;
						prog_r     <= cbyte[CTL_PROG_BIT];
						erase_r    <= cbyte[CTL_ERASE_BIT];
					end
				end
				NV_WAIT: begin
					wait_cnt_r <= wait_cnt_r + CNT_W'(1);
					if (wait_done) begin
						nv_r       <= NV_COPY;
						copy_idx_r <= '0;
					end
				end
				NV_COPY: begin
					copy_idx_r <= copy_idx_r + AW'(1);
					if (copy_done) begin
						nv_r    <= NV_IDLE;
						busy_r  <= 1'b0;
						prog_r  <= 1'b0;
						erase_r <= 1'b0;
					end
				end
			endcase
		end
	end

	assign nonvolatile_busy_flag = busy_r;

	// ----------------------------------------------------------------
	// live crc scanner
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int b = 0; b < 8; b++) begin
			x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
		end
		return x;
	endfunction

	wire [7:0] crc_seed = (crc_idx_r == '0) ? CRC_INIT : crc_acc_r;
	wire [7:0] crc_next = crc8_step(crc_seed, sram_r[crc_idx_r]);

	// R01 live crc over sram
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			crc_idx_r  <= '0;
			crc_acc_r  <= CRC_INIT;
			live_crc_r <= RST_BYTE;
		end else begin
			crc_idx_r <= crc_idx_r + AW'(1);
			crc_acc_r <= crc_next;
			if (crc_idx_r == AW'(ARRAY_DEPTH - 1)) begin
				live_crc_r <= crc_next;
			end
		end
	end
endmodule // nsa_top
`default_nettype wire

// >>> pkg/nsa_pkg.sv
// Purpose: shared constants for the indirect array access block
// Assumes: register pointer and data bytes arrive from an i2c slave front end
// Notes:   offsets are register numbers as seen by the i2c host
package nsa_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTL      = 8'h31;
	localparam logic [7:0] OFS_CRC      = 8'h32;
	localparam logic [7:0] OFS_ADR      = 8'h33;
	localparam logic [7:0] OFS_EEP      = 8'h34;
	localparam logic [7:0] OFS_RAM      = 8'h35;
	localparam logic [7:0] OFS_KEY      = 8'h38;

	// ----------------------------------------------------------------
	// fields and values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [7:0] UNLOCK_CODE  = 8'hBE;
	localparam logic [7:0] ERASED_BYTE  = 8'h00;
	localparam logic [7:0] CRC_POLY     = 8'h07;
	localparam logic [7:0] CRC_INIT     = 8'h00;
	localparam int         CTL_PROG_BIT  = 0;
	localparam int         CTL_ERASE_BIT = 1;
	localparam int         CTL_BUSY_BIT  = 2;
	localparam int         ADR_FIELD_W   = 7;
	localparam int         ARRAY_ADDR_W  = 5;
	localparam int         ARRAY_DEPTH   = 32;

	// ----------------------------------------------------------------
	// command stream
	// ----------------------------------------------------------------
	localparam int         CMD_W        = 10;
	localparam logic [1:0] KIND_START   = 2'h0;
	localparam logic [1:0] KIND_WRITE   = 2'h1;
	localparam logic [1:0] KIND_READ    = 2'h2;
	localparam logic [1:0] KIND_STOP    = 2'h3;
	localparam int         FIFO_DEPTH   = 8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS   = 100;
	localparam int         NV_CYCLE_MS     = 115;
	localparam int         NV_CYCLE_CYCLES = NV_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// >>> pkg/nsa_stream_if.sv
// Purpose: valid/ready byte stream between the block's modules
// Assumes: single clock
// Notes:   data width is a parameter
`timescale 1ns/1ps
`default_nettype none
interface nsa_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // nsa_stream_if
`default_nettype wire

// >>> tb/nsa_host.sv
// Purpose: i2c host side, command stream
// Assumes: tasks entered just after a rising edge
// Notes:   lines released after stop
`timescale 1ns/1ps
`default_nettype none
module nsa_host
	import nsa_pkg::*;
(
	// clock
	input  wire logic      ref_clk,
	// command stream
	output var logic       cmd_valid,
	output var logic [1:0] cmd_kind,
	output var logic [7:0] cmd_data,
	input  wire logic      cmd_ready
);
	initial begin
		cmd_valid = 1'b0;
		cmd_kind  = KIND_STOP;
		cmd_data  = 8'h00;
	end
	// hold command until taken
	task automatic send(input logic [1:0] k, input logic [7:0] d);
		cmd_valid <= 1'b1;
		cmd_kind  <= k;
		cmd_data  <= d;
		@(posedge ref_clk);
		// stalls are bounded by the bench watchdog
		while (cmd_ready !== 1'b1)
			@(posedge ref_clk);
	endtask
	task automatic st(input logic [7:0] p); send(KIND_START, p); endtask
	task automatic wr(input logic [7:0] d); send(KIND_WRITE, d); endtask
	task automatic rd(); send(KIND_READ, 8'h00); endtask
	task automatic sp();
		send(KIND_STOP, 8'h00);
		cmd_valid <= 1'b0;
		cmd_data  <= 8'hFF;
		@(posedge ref_clk);
	endtask
	task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
		st(p);
		wr(d);
		sp();
	endtask
	task automatic rd_n(input logic [7:0] p, input int n);
		st(p);
		repeat (n) rd();
		sp();
	endtask
	task automatic unlock(input logic [7:0] key);
		wr_reg(OFS_KEY, key);
	endtask
endmodule // nsa_host
`default_nettype wire

// >>> tb/nsa_top_checker.sv
// Purpose: port checks for nsa_top
// Assumes: sees only top ports
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module nsa_top_checker
	import nsa_pkg::*;
#(
	parameter int PROG_CYCLES = 20
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	// command stream
	input wire logic       cmd_valid,
	input wire logic [1:0] cmd_kind,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_ready,
	// answers and status
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic       nonvolatile_busy_flag
);
	localparam int LAT_MIN  = 2;
	localparam int LAT_MAX  = 10;
	localparam int BUSY_LEN = PROG_CYCLES + 32;
	wire         take    = cmd_valid && cmd_ready;
	wire         rd_take = take && (cmd_kind == KIND_READ);
	logic [4:0]  pend_r;
	logic [3:0]  wr_age_r;
	logic [31:0] busy_cnt_r;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pend_r     <= 5'h00;
			wr_age_r   <= 4'hF;
			busy_cnt_r <= 32'h0;
		end else begin
			pend_r     <= pend_r + 5'(rd_take) - 5'(rd_valid);
			wr_age_r   <= (take && cmd_kind == KIND_WRITE) ? 4'h0 : wr_age_r + 4'(wr_age_r != 4'hF);
			busy_cnt_r <= nonvolatile_busy_flag ? busy_cnt_r + 32'h1 : 32'h0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_reset_clears: assert property ($fell(sys_rst) |-> !rd_valid && !cmd_ready && rd_data == RST_BYTE)
		else $error("outputs not cleared by reset");
	a_ready_release: assert property ($fell(sys_rst) |=> cmd_ready)
		else $error("command ready late after reset");
	a_data_hold: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data changed without answer");
	a_read_answer: assert property (rd_take && !nonvolatile_busy_flag
		|-> ##[LAT_MIN:LAT_MAX] (rd_valid || nonvolatile_busy_flag))
		else $error("read not answered in time");
	a_no_stray: assert property (rd_valid |-> pend_r != 5'h00)
		else $error("answer without read");
	a_busy_cause: assert property ($rose(nonvolatile_busy_flag) |-> wr_age_r <= 4'hA)
		else $error("busy without control write");
	a_busy_len: assert property ($fell(nonvolatile_busy_flag) |-> busy_cnt_r == 32'(BUSY_LEN))
		else $error("busy length wrong");
	a_busy_bound: assert property (busy_cnt_r <= 32'(BUSY_LEN))
		else $error("busy too long");
	c_read: cover property (rd_valid);
	c_busy: cover property ($rose(nonvolatile_busy_flag));
	c_full: cover property (cmd_valid && !cmd_ready);
endmodule // nsa_top_checker
bind nsa_top nsa_top_checker #(.PROG_CYCLES(PROG_CYCLES)) nsa_top_checker_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
	.cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .nonvolatile_busy_flag(nonvolatile_busy_flag)
);
`default_nettype wire

// >>> tb/nsa_top_test.sv
// Purpose: self-checking bench for nsa_top
// Assumes: short program cycle
// Notes:   answers queued in order
`timescale 1ns/1ps
`default_nettype none
module nsa_top_test
	import nsa_pkg::*;
;
	localparam int PROG = 20;
	localparam logic [7:0] PAT [4] = '{8'hC3, 8'h5A, 8'h96, 8'h0F};
	logic       ref_clk;
	logic       sys_rst;
	logic       cmd_valid;
	logic [1:0] cmd_kind;
	logic [7:0] cmd_data;
	logic       cmd_ready;
	logic       rd_valid;
	logic [7:0] rd_data;
	logic       busy;
	logic [7:0] ans_q [$];
	int         n_fail = 0;
	int         n_tests = 0;
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;
	nsa_top #(.PROG_CYCLES(PROG), .CMD_DEPTH(FIFO_DEPTH)) nsa_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .nonvolatile_busy_flag(busy));
	nsa_host nsa_host_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready));
	always @(posedge ref_clk)
		if (rd_valid === 1'b1) ans_q.push_back(rd_data);
	task automatic fail(input string m);
		n_fail++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic chk_rd(input logic [7:0] e);
		for (int i = 0; i < 200 && ans_q.size() == 0; i++)
			@(posedge ref_clk);
		n_tests++;
		if (ans_q.size() == 0) begin
			fail("no read answer");
		end else begin
			if (ans_q[0] !== e) fail($sformatf("read %h want %h", ans_q[0], e));
			void'(ans_q.pop_front());
		end
	endtask
	task automatic chk_busy(input logic e, input int lim);
		for (int i = 0; i < lim && busy !== e; i++)
			@(posedge ref_clk);
		n_tests++;
		if (busy !== e) fail("busy flag");
	endtask
	// expected crc over the sram image left by t_sram
	function automatic logic [7:0] crc_ref();
		logic [7:0] c;
		logic [7:0] b;
		c = CRC_INIT;
		for (int a = 0; a < ARRAY_DEPTH; a++) begin
			b = (a == 30) ? PAT[0] : (a == 31) ? PAT[1] : (a == 0) ? PAT[2] : (a == 1) ? PAT[3] : 8'h00;
			c = c ^ b;
			for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
	task automatic t_reset();
		nsa_host_i.rd_n(OFS_CRC, 2);
		chk_rd(RST_BYTE);
		chk_rd(RST_BYTE);
		nsa_host_i.rd_n(OFS_KEY, 2);
		chk_rd(RST_BYTE);
		chk_rd(RST_BYTE);
	endtask
	task automatic t_sram();
		nsa_host_i.wr_reg(OFS_ADR, 8'hFF);
		nsa_host_i.rd_n(OFS_ADR, 1);
		chk_rd(8'h7F);
		nsa_host_i.wr_reg(OFS_ADR, 8'h3E);
		nsa_host_i.st(OFS_RAM);
		for (int k = 0; k < 4; k++) nsa_host_i.wr(PAT[k]);
		nsa_host_i.sp();
		nsa_host_i.rd_n(OFS_ADR, 1);
		chk_rd(8'h3E);
		nsa_host_i.wr_reg(OFS_ADR, 8'h5E);
		nsa_host_i.rd_n(OFS_RAM, 4);
		for (int k = 0; k < 4; k++) chk_rd(PAT[k]);
		repeat (70) @(posedge ref_clk);
		nsa_host_i.rd_n(OFS_CRC, 1);
		chk_rd(crc_ref());
	endtask
	task automatic t_prog();
		nsa_host_i.unlock(UNLOCK_CODE);
		nsa_host_i.wr_reg(OFS_CTL, 8'h01);
		chk_busy(1'b1, 10);
		nsa_host_i.rd_n(OFS_CTL, 1);
		chk_rd(8'h05);
		fork
			nsa_host_i.rd_n(OFS_EEP, 8);
			begin
				for (int i = 0; i < 100 && cmd_ready !== 1'b0; i++) @(posedge ref_clk);
				n_tests++;
				if (cmd_ready !== 1'b0 || busy !== 1'b1) fail("queue not full");
				chk_busy(1'b0, 100);
				n_tests++;
				if (ans_q.size() != 0) fail("eeprom read during busy");
			end
		join
		for (int k = 0; k < 8; k++) chk_rd(k < 4 ? PAT[k] : 8'h00);
		nsa_host_i.rd_n(OFS_ADR, 4);
		chk_rd(8'h5E);
		for (int k = 0; k < 3; k++) chk_rd(PAT[k]);
	endtask
	task automatic t_nokey();
		nsa_host_i.unlock(8'hBD);
		nsa_host_i.wr_reg(OFS_CTL, 8'h01);
		repeat (40) @(posedge ref_clk);
		chk_busy(1'b0, 1);
		nsa_host_i.unlock(UNLOCK_CODE);
		nsa_host_i.rd_n(OFS_ADR, 1);
		chk_rd(8'h5E);
		nsa_host_i.wr_reg(OFS_CTL, 8'h01);
		repeat (40) @(posedge ref_clk);
		chk_busy(1'b0, 1);
		nsa_host_i.unlock(UNLOCK_CODE);
		nsa_host_i.wr_reg(OFS_CTL, 8'h02);
		chk_busy(1'b1, 10);
		chk_busy(1'b0, 100);
		nsa_host_i.rd_n(OFS_EEP, 1);
		chk_rd(ERASED_BYTE);
		nsa_host_i.unlock(UNLOCK_CODE);
		nsa_host_i.wr_reg(OFS_CTL, 8'h03);
		nsa_host_i.rd_n(OFS_CTL, 1);
		chk_rd(8'h07);
		chk_busy(1'b0, 100);
		nsa_host_i.rd_n(OFS_EEP, 1);
		chk_rd(PAT[0]);
	endtask
	task automatic results();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_sram();
		t_prog();
		t_nokey();
		results();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail("watchdog");
		results();
	end
endmodule // nsa_top_test
`default_nettype wire
